// ===== src/clock_strap_pkg.sv
/*
 * Constants for the platform clock strap block: register offsets, field
 * positions, reset values, ratio codes and frequency limits.
 * Assumes a 32-bit AXI4-Lite register bus and one clock domain.
 */
// Functional notes
// - platform clock is system input clock times ratio from four straps
// - codes 0010..0110 give 2..6, 1000 gives 8, 1001 gives 9, others reserved
// - memory bus clock is half the platform clock
// - local bus clocks are platform clock divided by programmed divider, with dividers below 2 used as 2
// - weak strap pull-ups are enabled only while held in reset
package clock_strap_pkg;
    // register byte offsets
    localparam logic [7:0] strap_status_off = 8'h00;
    localparam logic [7:0] clock_ctrl_off   = 8'h04;
    localparam logic [7:0] freq_status_off  = 8'h08;

    // strap status fields
    localparam int ss_ratio_straps_pos = 0;   // [3:0]
    localparam int ss_ratio_pos        = 4;   // [7:4]
    localparam int ss_ratio_valid_pos  = 8;
    localparam int ss_freq_strap_pos   = 9;
    localparam int ss_dram_type_pos    = 10;  // [11:10]
    localparam int ss_captured_pos     = 12;

    // clock control fields
    localparam int cc_divider_pos = 0;        // [4:0]
    localparam int divider_w      = 5;
    localparam logic [4:0] divider_rst = 5'h08;
    localparam logic [4:0] divider_min = 5'h02;

    // frequency status fields
    localparam int fs_plat_mhz_pos   = 0;     // [15:0]
    localparam int fs_band_bad_pos   = 16;
    localparam int fs_mem_bad_pos    = 17;
    localparam int fs_lbus_bad_pos   = 18;

    // ratio strap codes
    localparam logic [3:0] code_r2 = 4'h2;
    localparam logic [3:0] code_r3 = 4'h3;
    localparam logic [3:0] code_r4 = 4'h4;
    localparam logic [3:0] code_r5 = 4'h5;
    localparam logic [3:0] code_r6 = 4'h6;
    localparam logic [3:0] code_r8 = 4'h8;
    localparam logic [3:0] code_r9 = 4'h9;

    // frequency limits in MHz
    localparam logic [15:0] plat_gap_lo_mhz = 16'h0190;  // 400
    localparam logic [15:0] plat_gap_hi_mhz = 16'h01f4;  // 500
    localparam logic [15:0] mem_min_mhz     = 16'h00c8;  // 200
    localparam logic [15:0] mem_max_mhz     = 16'h012c;  // 300
    localparam logic [15:0] lbus_min_mhz    = 16'h0019;  // 25
    localparam logic [15:0] lbus_max_mhz    = 16'h0085;  // 133

    // axi responses
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage : clock_strap_pkg

// ===== src/platform_clock_strap_config.sv
/*
 * Platform clock strap capture, ratio decode, memory bus and local bus
 * clock generation, range checks, and an AXI4-Lite register slave.
 * Assumes mclk stands in for the platform clock, all inputs synchronous
 * to mclk, and straps stable while hard_reset is high.
 */
`timescale 1ns/1ps
`default_nettype none
module platform_clock_strap_config #(
    parameter logic [7:0] sys_clk_mhz = 8'h64  // 100 mhz system input clock
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // board straps and hard reset
    input  wire logic        hard_reset,
    input  wire logic [3:0]  platform_ratio_straps,
    input  wire logic        platform_freq_strap,
    input  wire logic [1:0]  dram_type_straps,
    // clock and strap outputs
    output logic             strap_pullup_en,
    output logic             mem_bus_clock,
    output logic [2:0]       local_bus_output_clocks,
    output logic [3:0]       platform_ratio,
    output logic             platform_ratio_valid,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // strap capture state
    logic       hr_prev_q,   hr_prev_d;
    logic       pullup_q,    pullup_d;
    logic [3:0] straps_q,    straps_d;
    logic [3:0] ratio_q,     ratio_d;
    logic       valid_q,     valid_d;
    logic       fstrap_q,    fstrap_d;
    logic [1:0] dram_q,      dram_d;
    logic       captured_q,  captured_d;
    // clock generation state
    logic [4:0] divider_q,   divider_d;
    logic [4:0] lb_cnt_q,    lb_cnt_d;
    logic       mem_clk_q,   mem_clk_d;
    logic [2:0] lb_clk_q,    lb_clk_d;
    logic [4:0] div_eff;
    // frequency checks
    logic [15:0] plat_mhz;
    logic [15:0] mem_mhz;
    logic [15:0] div_wide;
    logic        band_bad;
    logic        mem_bad;
    logic        lbus_bad;
    // bus state
    logic        awready_q,  awready_d;
    logic        wready_q,   wready_d;
    logic        bvalid_q,   bvalid_d;
    logic [1:0]  bresp_q,    bresp_d;
    logic        arready_q,  arready_d;
    logic        rvalid_q,   rvalid_d;
    logic [1:0]  rresp_q,    rresp_d;
    logic [31:0] rdata_q,    rdata_d;
    logic [31:0] rd_word;
    logic        rd_hit;

    // decode straps into ratio and capture at hard reset release
    always_comb begin
        hr_prev_d  = hard_reset;
        pullup_d   = hard_reset;
        straps_d   = straps_q;
        ratio_d    = ratio_q;
        valid_d    = valid_q;
        fstrap_d   = fstrap_q;
        dram_d     = dram_q;
        captured_d = captured_q;
        if (hard_reset) begin
            captured_d = 1'b0;
        end else if (hr_prev_q) begin
            straps_d   = platform_ratio_straps;
            fstrap_d   = platform_freq_strap;
            dram_d     = dram_type_straps;
            captured_d = 1'b1;
            valid_d    = 1'b1;
            case (platform_ratio_straps)
                clock_strap_pkg::code_r2: ratio_d = 4'h2;
                clock_strap_pkg::code_r3: ratio_d = 4'h3;
                clock_strap_pkg::code_r4: ratio_d = 4'h4;
                clock_strap_pkg::code_r5: ratio_d = 4'h5;
                clock_strap_pkg::code_r6: ratio_d = 4'h6;
                clock_strap_pkg::code_r8: ratio_d = 4'h8;
                clock_strap_pkg::code_r9: ratio_d = 4'h9;
                default: begin
                    ratio_d = 4'h0;
                    valid_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hr_prev_q  <= 1'b1;
            pullup_q   <= 1'b1;
            straps_q   <= 4'h0;
            ratio_q    <= 4'h0;
            valid_q    <= 1'b0;
            fstrap_q   <= 1'b0;
            dram_q     <= 2'h0;
            captured_q <= 1'b0;
        end else begin
            hr_prev_q  <= hr_prev_d;
            pullup_q   <= pullup_d;
            straps_q   <= straps_d;
            ratio_q    <= ratio_d;
            valid_q    <= valid_d;
            fstrap_q   <= fstrap_d;
            dram_q     <= dram_d;
            captured_q <= captured_d;
        end
    end

    // platform, memory and local bus frequency checks
    assign plat_mhz = 16'(sys_clk_mhz) * 16'(ratio_q);
    assign mem_mhz  = plat_mhz >> 1;
    assign div_wide = 16'(div_eff);
    assign band_bad = (plat_mhz > clock_strap_pkg::plat_gap_lo_mhz)
                   && (plat_mhz < clock_strap_pkg::plat_gap_hi_mhz);
    assign mem_bad  = (mem_mhz < clock_strap_pkg::mem_min_mhz)
                   || (mem_mhz > clock_strap_pkg::mem_max_mhz);
    assign lbus_bad = (plat_mhz < 16'(clock_strap_pkg::lbus_min_mhz * div_wide))
                   || (plat_mhz > 16'(clock_strap_pkg::lbus_max_mhz * div_wide));
    assign div_eff  = (divider_q < clock_strap_pkg::divider_min)
                    ? clock_strap_pkg::divider_min : divider_q;

    // memory bus clock and divided local bus clocks, idle in hard reset
    always_comb begin
        mem_clk_d = 1'b0;
        lb_cnt_d  = 5'h00;
        lb_clk_d  = 3'h0;
        if (!hard_reset && captured_q) begin
            mem_clk_d = ~mem_clk_q;
            lb_cnt_d  = (lb_cnt_q >= div_eff - 5'h01) ? 5'h00 : lb_cnt_q + 5'h01;
            lb_clk_d  = {3{lb_cnt_d < (div_eff >> 1)}};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_clk_q <= 1'b0;
            lb_cnt_q  <= 5'h00;
            lb_clk_q  <= 3'h0;
        end else begin
            mem_clk_q <= mem_clk_d;
            lb_cnt_q  <= lb_cnt_d;
            lb_clk_q  <= lb_clk_d;
        end
    end

    // read word mux
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (s_axi_araddr == clock_strap_pkg::strap_status_off) begin
            rd_word[clock_strap_pkg::ss_ratio_straps_pos +: 4] = straps_q;
            rd_word[clock_strap_pkg::ss_ratio_pos +: 4]        = ratio_q;
            rd_word[clock_strap_pkg::ss_ratio_valid_pos]       = valid_q;
            rd_word[clock_strap_pkg::ss_freq_strap_pos]        = fstrap_q;
            rd_word[clock_strap_pkg::ss_dram_type_pos +: 2]    = dram_q;
            rd_word[clock_strap_pkg::ss_captured_pos]          = captured_q;
        end else if (s_axi_araddr == clock_strap_pkg::clock_ctrl_off) begin
            rd_word[clock_strap_pkg::cc_divider_pos +: clock_strap_pkg::divider_w] = divider_q;
        end else if (s_axi_araddr == clock_strap_pkg::freq_status_off) begin
            rd_word[clock_strap_pkg::fs_plat_mhz_pos +: 16] = plat_mhz;
            rd_word[clock_strap_pkg::fs_band_bad_pos]       = band_bad;
            rd_word[clock_strap_pkg::fs_mem_bad_pos]        = mem_bad;
            rd_word[clock_strap_pkg::fs_lbus_bad_pos]       = lbus_bad;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // axi4-lite slave: take address and data together, answer next cycle
    always_comb begin
        awready_d = 1'b0;
        wready_d  = 1'b0;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        arready_d = 1'b0;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        divider_d = divider_q;
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (awready_q) begin
            bvalid_d = 1'b1;
        end else if (s_axi_awvalid && s_axi_wvalid && !bvalid_q) begin
            awready_d = 1'b1;
            wready_d  = 1'b1;
            bresp_d   = clock_strap_pkg::resp_okay;
            if (s_axi_awaddr == clock_strap_pkg::clock_ctrl_off) begin
                if (s_axi_wstrb[0]) begin
                    divider_d = s_axi_wdata[clock_strap_pkg::cc_divider_pos +:
                                            clock_strap_pkg::divider_w];
                end
            end else if (s_axi_awaddr != clock_strap_pkg::strap_status_off
                      && s_axi_awaddr != clock_strap_pkg::freq_status_off) begin
                bresp_d = clock_strap_pkg::resp_slverr;
            end
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (arready_q) begin
            rvalid_d = 1'b1;
        end else if (s_axi_arvalid && !rvalid_q) begin
            arready_d = 1'b1;
            rdata_d   = rd_word;
            rresp_d   = rd_hit ? clock_strap_pkg::resp_okay : clock_strap_pkg::resp_slverr;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h0000_0000;
            divider_q <= clock_strap_pkg::divider_rst;
        end else begin
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            divider_q <= divider_d;
        end
    end

    // outputs straight from flops
    assign strap_pullup_en         = pullup_q;
    assign mem_bus_clock           = mem_clk_q;
    assign local_bus_output_clocks = lb_clk_q;
    assign platform_ratio          = ratio_q;
    assign platform_ratio_valid    = valid_q;
    assign s_axi_awready           = awready_q;
    assign s_axi_wready            = wready_q;
    assign s_axi_bvalid            = bvalid_q;
    assign s_axi_bresp             = bresp_q;
    assign s_axi_arready           = arready_q;
    assign s_axi_rvalid            = rvalid_q;
    assign s_axi_rresp             = rresp_q;
    assign s_axi_rdata             = rdata_q;
endmodule : platform_clock_strap_config
`default_nettype wire

// ===== tb/board_strap_model.sv
/*
 * board model: strap drivers and hard reset source.
 * assumes the bench supplies codes and a one-cycle go pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module board_strap_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // commands from the bench
    input  wire logic       go,
    input  wire logic       freq_in,
    input  wire logic [3:0] code_in,
    input  wire logic [1:0] dram_in,
    // board pins
    output logic            hard_reset,
    output logic            platform_freq_strap,
    output logic [3:0]      platform_ratio_straps,
    output logic [1:0]      dram_type_straps
);
    logic [2:0] cnt_q;
    assign hard_reset = cnt_q != 3'h0;
    // count out the hard reset pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) cnt_q <= 3'h6;
        else if (go) cnt_q <= 3'h6;
        else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    end
    // ratio and freq straps driven in reset, a toggling pattern once released; dram straps always follow dram_in
    always_ff @(posedge mclk) begin
        if (hard_reset) begin
            platform_ratio_straps <= code_in;
            platform_freq_strap   <= freq_in && code_in != 4'h4;
        end else begin
            platform_ratio_straps <= ~platform_ratio_straps;
            platform_freq_strap   <= ~platform_freq_strap;
        end
        dram_type_straps <= dram_in;
    end
endmodule : board_strap_model
`default_nettype wire

// ===== tb/platform_clock_strap_config_checker.sv
/*
 * checker for strap capture, decode and clock outputs.
 * assumes binding to the top module, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module platform_clock_strap_config_checker (
    // clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // board side
    input wire logic       hard_reset,
    input wire logic [3:0] platform_ratio_straps,
    // watched outputs
    input wire logic       strap_pullup_en,
    input wire logic       mem_bus_clock,
    input wire logic       platform_ratio_valid,
    input wire logic       s_axi_bvalid,
    input wire logic [3:0] platform_ratio,
    input wire logic [2:0] local_bus_output_clocks
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // defined codes carry their own ratio value
    function automatic logic [3:0] dec(input logic [3:0] c);
        return (c inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9}) ? c : 4'h0;
    endfunction : dec
    property p_pullup_on; hard_reset |=> strap_pullup_en; endproperty
    a_pullup_on: assert property (p_pullup_on) else $error("pullup off in reset");
    property p_pullup_off; !hard_reset |=> !strap_pullup_en; endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pullup on after reset");
    property p_mem_fall; mem_bus_clock |=> !mem_bus_clock; endproperty
    a_mem_fall: assert property (p_mem_fall) else $error("memory clock high twice");
    property p_mem_rise; !mem_bus_clock && $past(mem_bus_clock) && !hard_reset |=> mem_bus_clock;
    endproperty
    a_mem_rise: assert property (p_mem_rise) else $error("memory clock stalled");
    property p_stop; hard_reset |=> local_bus_output_clocks == 3'h0 && !mem_bus_clock;
    endproperty
    a_stop: assert property (p_stop) else $error("clocks run in reset");
    property p_lbus_eq; local_bus_output_clocks inside {3'h0, 3'h7}; endproperty
    a_lbus_eq: assert property (p_lbus_eq) else $error("local clocks differ");
    property p_decode; platform_ratio == dec(platform_ratio) &&
        platform_ratio_valid == (platform_ratio != 4'h0); endproperty
    a_decode: assert property (p_decode) else $error("ratio not a defined value");
    property p_capture; !hard_reset && $past(hard_reset) |=>
        platform_ratio == dec($past(platform_ratio_straps)); endproperty
    a_capture: assert property (p_capture) else $error("ratio not captured");
    property p_hold; !hard_reset && $past(!hard_reset) && $past(!hard_reset, 2) &&
        !$past(rst, 2) |-> $stable(platform_ratio) && $stable(platform_ratio_valid); endproperty
    a_hold: assert property (p_hold) else $error("ratio changed outside reset");
    c_capture: cover property ($fell(hard_reset));
    c_lbus: cover property ($rose(local_bus_output_clocks[0]));
    c_write: cover property (s_axi_bvalid);
endmodule : platform_clock_strap_config_checker
bind platform_clock_strap_config platform_clock_strap_config_checker u_chk (.*);
`default_nettype wire

// ===== tb/platform_clock_strap_config_test.sv
/*
 * bench: board model drives straps, tasks speak axi4-lite, a monitor
 * compares answers and local clock periods with queued expectations.
 */
`timescale 1ns/1ps
`default_nettype none
module platform_clock_strap_config_test;
    logic        mclk = 1'b0, rst = 1'b1, go = 1'b0, freq_in = 1'b0, s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, hard_reset, platform_freq_strap, strap_pullup_en;
    logic        mem_bus_clock, platform_ratio_valid, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, lb_prev = 1'b0, armed = 1'b0;
    logic [3:0]  code_in = 4'h0, s_axi_wstrb = 4'h0, platform_ratio_straps, platform_ratio;
    logic [1:0]  dram_in = 2'h0, dram_type_straps, s_axi_bresp, s_axi_rresp;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [2:0]  local_bus_output_clocks;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          pq[$];
    int          miscompares = 0, n_checks = 0, cnt = 0, d = 8;
    always #25 mclk = ~mclk;
    board_strap_model board (.*);
    platform_clock_strap_config #(.sys_clk_mhz(8'h64)) uut (.*);
    // ratio of a strap code, zero when reserved
    function automatic logic [3:0] dec(input logic [3:0] c);
        return (c inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9}) ? c : 4'h0;
    endfunction : dec
    // frequency status word with an okay response on top
    function automatic logic [33:0] fs(input int r, input int dv);
        int f;
        f = 100 * r;
        if (dv < 2) dv = 2;
        return {15'h0, f > 133 * dv || f < 25 * dv, f < 400 || f > 600,
                f > 400 && f < 500, 16'(f)};
    endfunction : fs
    task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] e);
        bq.push_back(e);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(posedge mclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge mclk); while (!s_axi_bvalid);
        s_axi_bready  <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (!s_axi_rvalid);
        s_axi_rready  <= 1'b0;
        @(posedge mclk);
    endtask : rd
    task automatic final_report;
        if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // answers and local clock periods against the oldest note
    always @(posedge mclk) begin
        if (s_axi_rvalid && s_axi_rready) cmp("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready) cmp("bresp", bq.pop_front(), 34'(s_axi_bresp));
        cnt++;
        if (local_bus_output_clocks[0] && !lb_prev) begin
            if (armed && pq.size() != 0) cmp("period", 34'(pq.pop_front()), 34'(cnt));
            armed = pq.size() != 0;
            cnt = 0;
        end
        lb_prev = local_bus_output_clocks[0];
    end
    // main sequence: every strap code, then divider settings and refusals
    initial begin
        void'($urandom(41));
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            code_in <= 4'(c) ^ 4'h6;
            freq_in <= 1'($urandom);
            dram_in <= 2'($urandom);
            @(posedge mclk);
            go <= 1'b1;
            @(posedge mclk);
            go <= 1'b0;
            repeat (12) @(posedge mclk);
            rd(8'h00, {22'h1, dram_in, freq_in && code_in != 4'h4, dec(code_in) != 4'h0,
               dec(code_in), code_in});
            rd(8'h08, fs(int'(dec(code_in)), d));
        end
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 1 : $urandom_range(31, 2);
            wr(8'h04, 32'(d), 4'hf, 2'h0);
            pq.push_back(d < 2 ? 2 : d);
            rd(8'h04, 34'(d));
            rd(8'h08, fs(9, d));
            repeat (110) @(posedge mclk);
        end
        wr(8'h04, 32'h1f, 4'h0, 2'h0);
        wr(8'h08, 32'hffff, 4'hf, 2'h0);
        rd(8'h04, 34'(d));
        rd(8'h08, fs(9, d));
        wr(8'h0c, 32'h1, 4'hf, clock_strap_pkg::resp_slverr);
        rd(8'h0c, {clock_strap_pkg::resp_slverr, 32'h0});
        repeat (4) @(posedge mclk);
        final_report;
    end
    // the run needs about 870 cycles; stop a hang well beyond that
    initial begin
        #300000;
        miscompares++;
        final_report;
    end
endmodule : platform_clock_strap_config_test
`default_nettype wire
